// >>> rtl/hpp_pkg.sv
// package for the handwheel pulse positioning block: map, limits, timing, carriers
// assumes a 250 MHz core clock and a 32-bit AXI4-Lite register port
package hpp_pkg;
	// ****************************************
	// sizes
	// ****************************************
	localparam int HPP_AXES     = 32;
	localparam int HPP_GENS     = 3;
	localparam int HPP_SLOTS    = 2;
	localparam int HPP_MAX_SEL  = 3;
	localparam int HPP_ADDR_W   = 12;
	localparam int HPP_GAIN_W   = 9;
	localparam int HPP_CNT_W    = 16;
	localparam logic [31:0] HPP_ALL_AXES = 32'hFFFF_FFFF;
	localparam logic [31:0] HPP_RED_AXES = 32'h0000_00FF;
	// ****************************************
	// value limits and reset values
	// ****************************************
	localparam logic [15:0] HPP_MAG_MIN    = 16'h0001;
	localparam logic [15:0] HPP_MAG_MAX    = 16'h2710;
	localparam logic [15:0] HPP_MAG_DEF    = 16'h0001;
	localparam logic [5:0]  HPP_SMOOTH_MAX = 6'h3B;
	localparam logic [HPP_GAIN_W-1:0] HPP_GAIN_FULL = 9'h100;
	localparam int HPP_GAIN_SHIFT = 8;
	localparam logic [1:0] HPP_RESP_OKAY = 2'h0;
	localparam logic [1:0] HPP_RESP_ERR  = 2'h2;
	// ****************************************
	// timing
	// ****************************************
	localparam int HPP_CLK_MHZ   = 250;
	localparam int HPP_TICK_US   = 1000;
	localparam int HPP_SMOOTH_US = 56800;
	localparam int HPP_TICK_CYC  = HPP_TICK_US * HPP_CLK_MHZ;
	// one of 256 gain steps of one smoothing unit
	localparam int HPP_STEP_CYC  = HPP_SMOOTH_US * HPP_CLK_MHZ / 256;
	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [11:0] HPP_OFS_SEL0   = 12'h000;
	localparam logic [11:0] HPP_OFS_SEL1   = 12'h004;
	localparam logic [11:0] HPP_OFS_SEL2   = 12'h008;
	localparam logic [11:0] HPP_OFS_ENABLE = 12'h00C;
	localparam logic [11:0] HPP_OFS_SMO0   = 12'h010;
	localparam logic [11:0] HPP_OFS_SMO1   = 12'h014;
	localparam logic [11:0] HPP_OFS_SMO2   = 12'h018;
	localparam logic [11:0] HPP_OFS_ERRFLG = 12'h01C;
	localparam logic [11:0] HPP_OFS_ERR0   = 12'h020;
	localparam logic [11:0] HPP_OFS_ERR1   = 12'h024;
	localparam logic [11:0] HPP_OFS_ERR2   = 12'h028;
	localparam logic [11:0] HPP_OFS_VARIANT = 12'h02C;
	localparam logic [11:0] HPP_OFS_STATUS = 12'h030;
	localparam logic [4:0]  HPP_MAG_PAGE   = 5'h02;
	// ****************************************
	// carriers and states
	// ****************************************
	typedef struct packed {
		logic               valid;
		logic signed [31:0] travel;
	} hpp_axis_cmd_t;
	typedef enum logic [1:0] {HPP_IDLE, HPP_ACCEL, HPP_RUN, HPP_DECEL} hpp_gen_state_t;
endpackage : hpp_pkg

// >>> rtl/hpp_sync.sv
// two-stage synchroniser for a vector of pin levels
// assumes each bit is an independent slow level from outside the clock domain
`timescale 1ns/1ps
module hpp_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	import hpp_pkg::*;
	logic [W-1:0] meta_r;
	// first stage feeds only the second
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule : hpp_sync

// >>> rtl/hpp_gen_ctl.sv
// enable-flag sequencer with smoothing gain ramp for one pulse generator
// assumes enable comes from a register on the same clock
`timescale 1ns/1ps
module hpp_gen_ctl #(
	parameter int STEP_CYC = hpp_pkg::HPP_STEP_CYC
) (
	input  wire logic                          core_clk_i,
	input  wire logic                          srst_i,
	input  wire logic                          enable_i,
	input  wire logic [5:0]                    smooth_i,
	output logic                               rise_o,
	output logic                               busy_o,
	output logic [hpp_pkg::HPP_GAIN_W-1:0]     gain_o
);
	import hpp_pkg::*;
	hpp_gen_state_t state_r;
	logic           enable_d_r;
	logic [31:0]    step_cnt_r;
	logic [5:0]     smo_clamp;
	logic [31:0]    step_len;
	logic           step_done;
	// out-of-range smoothing is clamped to the largest legal value
	assign smo_clamp = (smooth_i > HPP_SMOOTH_MAX) ? HPP_SMOOTH_MAX : smooth_i; // R11
	assign step_len  = (32'(smo_clamp) + 32'd1) * 32'(STEP_CYC);              // R12
	assign step_done = (step_cnt_r >= step_len - 32'd1);
	// a re-enable during deceleration is lost; enable must rise again once the ramp has ended
	assign rise_o    = enable_i && !enable_d_r && (state_r == HPP_IDLE);
	assign busy_o    = (state_r != HPP_IDLE);
	// ****************************************
	// ramp sequencer
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_r    <= HPP_IDLE;
			enable_d_r <= 1'b0;
			step_cnt_r <= '0;
			gain_o     <= '0;
		end else begin
			enable_d_r <= enable_i;
			step_cnt_r <= (step_done || state_r == HPP_IDLE) ? 32'd0 : step_cnt_r + 32'd1;
			unique case (state_r)
				HPP_IDLE: begin
					if (rise_o) state_r <= HPP_ACCEL;
				end
				HPP_ACCEL: begin
					if (!enable_i) begin
						state_r <= HPP_DECEL;
					end else if (step_done) begin
						gain_o <= gain_o + 9'h001; // R11
						if (gain_o == HPP_GAIN_FULL - 9'h001) state_r <= HPP_RUN;
					end
				end
				HPP_RUN: begin
					if (!enable_i) state_r <= HPP_DECEL;
				end
				HPP_DECEL: begin
					if (step_done) begin
						gain_o <= (gain_o == '0) ? '0 : gain_o - 9'h001; // R11
						if (gain_o <= 9'h001) state_r <= HPP_IDLE;
					end
				end
			endcase
		end
	end
	a_gain_bounded: assert property (@(posedge core_clk_i) disable iff (srst_i) // R12
		gain_o <= HPP_GAIN_FULL) else $error("smoothing gain above full scale");
endmodule : hpp_gen_ctl

// >>> rtl/hpp_core.sv
// handwheel pulse positioning: generator pulses to per-axis travel each 1 ms
// assumes AXI4-Lite master on core_clk_i; pulse and slot pins are asynchronous
//
// Summary of operation
// R1: only lowest fitted input module counts
// R2: pulses move axes only while enabled
// R3: 32-bit axis mask per generator
// R4: travel is pulses times axis magnification
// R5: one travel LSB equals unit per pulse
// R6: speed is pulses per ms times magnification
// R7: 32 magnifications, legal 1 to 10000
// R8: enable rise checks magnification, flags, uses 1
// R9: reduced variant limits axes 1 to 8
// R10: operator keeps speed within motor limits
// R11: smoothing 0..59 shapes accel and decel
// R12: time constant is (smoothing+1) times 56.8 ms
// R13: one generator drives one to three axes
// R14: excess selection keeps lowest three axes
// R15: duplicate axis ignored, empty mask idle
// R16: count and apply travel every 1 ms
`timescale 1ns/1ps
module hpp_core #(
	parameter int TICK_CYC = hpp_pkg::HPP_TICK_CYC,
	parameter int STEP_CYC = hpp_pkg::HPP_STEP_CYC
) (
	input  wire logic                                        core_clk_i,
	input  wire logic                                        srst_i,
	input  wire logic [hpp_pkg::HPP_ADDR_W-1:0]              s_axi_awaddr,
	input  wire logic                                        s_axi_awvalid,
	output logic                                             s_axi_awready,
	input  wire logic [31:0]                                 s_axi_wdata,
	input  wire logic [3:0]                                  s_axi_wstrb,
	input  wire logic                                        s_axi_wvalid,
	output logic                                             s_axi_wready,
	output logic [1:0]                                       s_axi_bresp,
	output logic                                             s_axi_bvalid,
	input  wire logic                                        s_axi_bready,
	input  wire logic [hpp_pkg::HPP_ADDR_W-1:0]              s_axi_araddr,
	input  wire logic                                        s_axi_arvalid,
	output logic                                             s_axi_arready,
	output logic [31:0]                                      s_axi_rdata,
	output logic [1:0]                                       s_axi_rresp,
	output logic                                             s_axi_rvalid,
	input  wire logic                                        s_axi_rready,
	input  wire logic [hpp_pkg::HPP_SLOTS-1:0]               slot_fitted_i,
	input  wire logic [hpp_pkg::HPP_SLOTS*hpp_pkg::HPP_GENS-1:0] pg_pulse_i,
	input  wire logic [hpp_pkg::HPP_SLOTS*hpp_pkg::HPP_GENS-1:0] pg_dir_i,
	output hpp_pkg::hpp_axis_cmd_t [hpp_pkg::HPP_AXES-1:0]   axis_cmd_o
);
	import hpp_pkg::*;
	localparam int PW = HPP_SLOTS * HPP_GENS;
	// ****************************************
	// state
	// ****************************************
	logic [31:0]             sel_r [HPP_GENS];
	logic [5:0]              smo_r [HPP_GENS];
	logic [HPP_GENS-1:0]     enable_r;
	logic                    err_flag_r;
	logic [31:0]             err_r [HPP_GENS];
	logic                    reduced_r;
	logic [15:0]             mag_r [HPP_AXES];
	logic [15:0]             eff_mag_r [HPP_AXES];
	logic [31:0]             own_r [HPP_GENS];
	logic signed [HPP_CNT_W-1:0] acc_r [HPP_GENS];
	logic signed [HPP_CNT_W-1:0] cnt_ms_r [HPP_GENS];
	logic [31:0]             tick_cnt_r;
	logic                    tick_r;
	logic [PW-1:0]           pls_s, dir_s, pls_d_r;
	logic [HPP_SLOTS-1:0]    fit_s;
	logic [HPP_GENS-1:0]     rise, busy;
	logic [HPP_GAIN_W-1:0]   gain [HPP_GENS];
	logic [31:0]             new_own [HPP_GENS];
	logic [31:0]             bad [HPP_GENS];
	logic [31:0]             taken;
	// keeps only the lowest three set bits of a mask
	function automatic logic [31:0] first3(input logic [31:0] m);
		logic [31:0] r;
		int          n;
		r = '0;
		n = 0;
		for (int i = 0; i < HPP_AXES; i++) begin
			if (m[i] && n < HPP_MAX_SEL) begin
				r[i] = 1'b1;
				n++;
			end
		end
		return r;
	endfunction : first3
	// ****************************************
	// pins and generators
	// ****************************************
	hpp_sync #(.W(2*PW+HPP_SLOTS)) u_sync (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.async_i    ({slot_fitted_i, pg_dir_i, pg_pulse_i}),
		.sync_o     ({fit_s, dir_s, pls_s})
	);
	for (genvar g = 0; g < HPP_GENS; g++) begin : g_gen
		hpp_gen_ctl #(.STEP_CYC(STEP_CYC)) u_ctl (
			.core_clk_i (core_clk_i),
			.srst_i     (srst_i),
			.enable_i   (enable_r[g]),
			.smooth_i   (smo_r[g]),
			.rise_o     (rise[g]),
			.busy_o     (busy[g]),
			.gain_o     (gain[g])
		);
	end
	// only the lowest fitted slot supplies pulses; no slot means no pulses
	wire         use_slot1  = !fit_s[0] && fit_s[1];                       // R1
	wire         any_slot   = |fit_s;                                      // R1
	wire [PW-1:0] pls_edge  = pls_s & ~pls_d_r;
	wire [31:0]  valid_axes = reduced_r ? HPP_RED_AXES : HPP_ALL_AXES;     // R9
	// ****************************************
	// selection on enable rise
	// ****************************************
	// lower generator wins when two rise together; axes already owned are skipped
	always_comb begin
		taken = own_r[0] | own_r[1] | own_r[2];
		for (int g = 0; g < HPP_GENS; g++) begin
			new_own[g] = '0;
			bad[g]     = '0;
			if (rise[g]) begin
				new_own[g] = first3(sel_r[g] & valid_axes & ~taken); // R3 R13 R14 R15
				taken      = taken | new_own[g];
				for (int a = 0; a < HPP_AXES; a++) begin
					bad[g][a] = new_own[g][a] &&
					            (mag_r[a] < HPP_MAG_MIN || mag_r[a] > HPP_MAG_MAX); // R7 R8
				end
			end
		end
	end
	// ****************************************
	// pulse counting and ms tick
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
			pls_d_r    <= '0;
		end else begin
			tick_r     <= (tick_cnt_r == 32'(TICK_CYC - 2));                  // R16
			tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYC - 1)) ? 32'd0 : tick_cnt_r + 32'd1;
			pls_d_r    <= pls_s;
		end
	end
	for (genvar g = 0; g < HPP_GENS; g++) begin : g_cnt
		wire e0 = use_slot1 ? pls_edge[HPP_GENS+g] : pls_edge[g];
		wire d0 = use_slot1 ? dir_s[HPP_GENS+g] : dir_s[g];
		wire signed [HPP_CNT_W-1:0] step = (!any_slot || !e0) ? '0 : (d0 ? -16'sd1 : 16'sd1);
		// counting stops with the flag; deceleration replays the last rate
		always_ff @(posedge core_clk_i) begin
			if (srst_i || !busy[g]) begin
				acc_r[g]    <= '0;
				cnt_ms_r[g] <= '0;
			end else if (tick_r) begin
				acc_r[g]    <= enable_r[g] ? step : '0;                        // R2 R16
				cnt_ms_r[g] <= enable_r[g] ? acc_r[g] : cnt_ms_r[g];           // R6 R16
			end else if (enable_r[g]) begin
				acc_r[g] <= acc_r[g] + step;                                   // R2
			end
		end
	end
	// ****************************************
	// axis travel per ms
	// ****************************************
	// one LSB of travel is the per-pulse unit of the axis, so no unit scaling here
	for (genvar a = 0; a < HPP_AXES; a++) begin : g_axis
		logic signed [HPP_CNT_W-1:0] cnt;
		logic [HPP_GAIN_W-1:0]       gn;
		logic signed [47:0]          prod;
		always_comb begin
			cnt = '0;
			gn  = '0;
			for (int g = 0; g < HPP_GENS; g++) begin
				if (own_r[g][a]) begin
					cnt = cnt_ms_r[g];
					gn  = gain[g];
				end
			end
			prod = 48'(cnt) * 48'(signed'({1'b0, eff_mag_r[a]})) *
			       48'(signed'({1'b0, gn}));                                   // R4 R5 R6
		end
		always_ff @(posedge core_clk_i) begin
			if (srst_i) begin
				axis_cmd_o[a] <= '0;
				eff_mag_r[a]  <= HPP_MAG_DEF;
			end else begin
				axis_cmd_o[a].valid  <= tick_r;                                // R16
				axis_cmd_o[a].travel <= tick_r ? 32'(prod >>> HPP_GAIN_SHIFT) : 32'sd0;
				if (new_own[0][a] || new_own[1][a] || new_own[2][a])
					eff_mag_r[a] <= (bad[0][a] || bad[1][a] || bad[2][a]) ?
					                HPP_MAG_DEF : mag_r[a];                        // R8
			end
		end
	end
	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	wire         wr_go   = s_axi_awready && s_axi_wready;
	wire [11:0]  wa      = s_axi_awaddr;
	wire         wa_mag  = (wa[11:7] == HPP_MAG_PAGE);
	wire [31:0]  wd      = s_axi_wdata;
	wire         w_full  = &s_axi_wstrb;
	// clamp on write so a wide value never wraps into a small legal one
	wire [5:0]   smo_wd  = (wd > 32'(HPP_SMOOTH_MAX)) ? HPP_SMOOTH_MAX : wd[5:0]; // R11
	wire         ra_mag  = (s_axi_araddr[11:7] == HPP_MAG_PAGE);
	logic [31:0] rd_mux;
	logic        rd_hit;
	// read decode
	always_comb begin
		rd_hit = 1'b1;
		rd_mux = '0;
		if (ra_mag) begin
			rd_mux = {16'h0000, mag_r[s_axi_araddr[6:2]]};
		end else begin
			unique case (s_axi_araddr)
				HPP_OFS_SEL0:    rd_mux = sel_r[0];
				HPP_OFS_SEL1:    rd_mux = sel_r[1];
				HPP_OFS_SEL2:    rd_mux = sel_r[2];
				HPP_OFS_ENABLE:  rd_mux = {29'h0, enable_r};
				HPP_OFS_SMO0:    rd_mux = {26'h0, smo_r[0]};
				HPP_OFS_SMO1:    rd_mux = {26'h0, smo_r[1]};
				HPP_OFS_SMO2:    rd_mux = {26'h0, smo_r[2]};
				HPP_OFS_ERRFLG:  rd_mux = {31'h0, err_flag_r};
				HPP_OFS_ERR0:    rd_mux = err_r[0];
				HPP_OFS_ERR1:    rd_mux = err_r[1];
				HPP_OFS_ERR2:    rd_mux = err_r[2];
				HPP_OFS_VARIANT: rd_mux = {31'h0, reduced_r};
				HPP_OFS_STATUS:  rd_mux = own_r[0] | own_r[1] | own_r[2];
				default:         rd_hit = 1'b0;
			endcase
		end
	end
	// handshakes: one write and one read in flight, ready pulses for one cycle
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= HPP_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= HPP_RESP_OKAY;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !wr_go && !s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !wr_go && !s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wa_mag || wa <= HPP_OFS_VARIANT) ? HPP_RESP_OKAY : HPP_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_hit ? HPP_RESP_OKAY : HPP_RESP_ERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// register writes; hardware error set wins over a same-cycle clear
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			enable_r   <= '0;
			err_flag_r <= 1'b0;
			reduced_r  <= 1'b0;
			for (int g = 0; g < HPP_GENS; g++) begin
				sel_r[g] <= '0;
				smo_r[g] <= '0;
				err_r[g] <= '0;
				own_r[g] <= '0;
			end
			for (int a = 0; a < HPP_AXES; a++) mag_r[a] <= HPP_MAG_DEF;
		end else begin
			for (int g = 0; g < HPP_GENS; g++) begin
				own_r[g] <= rise[g] ? new_own[g] : (busy[g] ? own_r[g] : 32'h0); // R15
				if (wr_go && w_full && wa == HPP_OFS_SEL0 + 12'(4*g)) sel_r[g] <= wd;
				if (wr_go && w_full && wa == HPP_OFS_SMO0 + 12'(4*g)) smo_r[g] <= smo_wd;
				err_r[g] <= ((wr_go && w_full && wa == HPP_OFS_ERR0 + 12'(4*g)) ?
				             err_r[g] & ~wd : err_r[g]) | bad[g];             // R8
			end
			if (wr_go && w_full && wa == HPP_OFS_ENABLE) enable_r <= wd[2:0];
			if (wr_go && w_full && wa == HPP_OFS_VARIANT) reduced_r <= wd[0];
			if (wr_go && w_full && wa_mag) mag_r[wa[6:2]] <= wd[15:0];
			err_flag_r <= ((wr_go && w_full && wa == HPP_OFS_ERRFLG && wd[0]) ? 1'b0 :
			               err_flag_r) | (|(bad[0] | bad[1] | bad[2]));        // R8
		end
	end
	// ****************************************
	// assertions
	// ****************************************
	a_sel_three_max: assert property (@(posedge core_clk_i) disable iff (srst_i) // R13
		$countones(own_r[0]) <= 3 && $countones(own_r[1]) <= 3 &&
		$countones(own_r[2]) <= 3) else $error("generator owns more than three axes");
	a_own_disjoint: assert property (@(posedge core_clk_i) disable iff (srst_i) // R15
		(own_r[0] & own_r[1]) == 0 && (own_r[0] & own_r[2]) == 0 &&
		(own_r[1] & own_r[2]) == 0) else $error("axis owned twice");
	a_own_in_mask: assert property (@(posedge core_clk_i) disable iff (srst_i) // R3
		rise[0] |=> (own_r[0] & ~$past(sel_r[0])) == 0) else $error("owned axis not selected");
	a_lowest_three: assert property (@(posedge core_clk_i) disable iff (srst_i) // R14
		rise[0] && taken == new_own[0] && $countones(sel_r[0] & valid_axes) >= 3
		|=> $countones(own_r[0]) == 3) else $error("fewer than three axes taken");
	a_reduced_axes: assert property (@(posedge core_clk_i) disable iff (srst_i) // R9
		reduced_r && $stable(reduced_r) && (rise != 0) |=>
		((own_r[0] | own_r[1] | own_r[2]) & ~HPP_RED_AXES & ~$past(taken & ~new_own[0]
		& ~new_own[1] & ~new_own[2])) == 0) else $error("high axis used on reduced variant");
	a_err_on_bad: assert property (@(posedge core_clk_i) disable iff (srst_i) // R8
		(bad[2] != 0) |=> err_flag_r && (err_r[2] & $past(bad[2])) == $past(bad[2]))
		else $error("bad magnification not flagged");
	a_mag_legal: assert property (@(posedge core_clk_i) disable iff (srst_i) // R7
		eff_mag_r[0] >= HPP_MAG_MIN && eff_mag_r[0] <= HPP_MAG_MAX)
		else $error("applied magnification out of range");
	a_no_count_off: assert property (@(posedge core_clk_i) disable iff (srst_i) // R2
		!enable_r[0] && !tick_r |=> acc_r[0] == 0 || $stable(acc_r[0]))
		else $error("pulses counted while disabled");
	a_cmd_after_tick: assert property (@(posedge core_clk_i) disable iff (srst_i) // R16
		tick_r |=> axis_cmd_o[0].valid ##1 !axis_cmd_o[0].valid)
		else $error("travel not applied after tick");
	a_idle_axis_still: assert property (@(posedge core_clk_i) disable iff (srst_i) // R4
		!own_r[0][5] && !own_r[1][5] && !own_r[2][5] |=> axis_cmd_o[5].travel == 0)
		else $error("unowned axis moved");
	c_enable_rise: cover property (@(posedge core_clk_i) disable iff (srst_i) rise[0]);
	c_bad_mag: cover property (@(posedge core_clk_i) disable iff (srst_i) bad[2] != 0);
	c_motion: cover property (@(posedge core_clk_i) disable iff (srst_i)
		axis_cmd_o[0].valid && axis_cmd_o[0].travel != 0);
endmodule : hpp_core

// >>> sim/hpp_pg_model.sv
// hand-turned pulse generator model driving the six generator pins
// assumes the bench clock; the design synchronises pins itself
`timescale 1ns/1ps
module hpp_pg_model (
	input  wire logic       core_clk_i,
	output logic      [5:0] pulse_o,
	output logic      [5:0] dir_o
);
	// ****************************************
	// pulse trains
	// ****************************************
	// both pins idle low until a train is asked for
	initial begin
		pulse_o = 6'h00;
		dir_o   = 6'h00;
	end
	// two edges high, three low between pulses: shorter pulses could slip past the synchroniser
	task automatic send(input int idx, input int n, input logic neg);
		for (int k = 0; k < n; k++) begin
			@(posedge core_clk_i);
			pulse_o[idx] <= 1'b1;
			dir_o[idx]   <= neg;
			repeat (2) @(posedge core_clk_i);
			pulse_o[idx] <= 1'b0;
			repeat (2) @(posedge core_clk_i);
		end
	endtask : send
endmodule : hpp_pg_model

// >>> sim/handwheel_pulse_positioning_tb.sv
// self-checking bench for hpp_core: register bus, generators, axis travel
// assumes a short tick (100 cycles) and short smoothing steps (2 cycles)
`timescale 1ns/1ps
module handwheel_pulse_positioning_tb;
	import hpp_pkg::*;
	logic                                clk, srst, awvalid, awready, wvalid, wready;
	logic                                bvalid, bready, arvalid, arready, rvalid, rready;
	logic [11:0]                         awaddr, araddr;
	logic [31:0]                         wdata, rdata;
	logic [3:0]                          wstrb;
	logic [1:0]                          bresp, rresp, slot;
	logic [5:0]                          pulse_unit, dir;
	hpp_axis_cmd_t [HPP_AXES-1:0]        cmd;
	logic signed [31:0]                  acc [HPP_AXES] = '{default: '0};
	logic signed [31:0]                  base [HPP_AXES];
	int                                  n_fail, samples_checked, cyc;
	hpp_core #(.TICK_CYC(100), .STEP_CYC(2)) u_dut (.core_clk_i(clk), .srst_i(srst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.slot_fitted_i(slot), .pg_pulse_i(pulse_unit), .pg_dir_i(dir), .axis_cmd_o(cmd));
	hpp_pg_model u_pg (.core_clk_i(clk), .pulse_o(pulse_unit), .dir_o(dir));
	// ****************************************
	// clock, timeout, travel sums
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// sums per axis so tick alignment of the pulses does not matter
	always @(posedge clk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < HPP_AXES; i++) if (cmd[i].valid === 1'b1) acc[i] <= acc[i] + cmd[i].travel;
		if (cyc == 60000) begin
			n_fail++;
			give_verdict();
		end
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	function automatic logic [31:0] dlt(input int i);
		return acc[i] - base[i];
	endfunction : dlt
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic pa, pw;
		@(posedge clk);
		{pa, pw} = 2'b11;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa | pw) begin
			@(posedge clk);
			if (awready === 1'b1) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (wready === 1'b1) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		chk("bresp", bresp, HPP_RESP_OKAY);
		bready <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] rs);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		chk("rdata", rdata, exp);
		chk("rresp", rresp, rs);
		rready <= 1'b0;
	endtask : rchk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		rchk(HPP_OFS_SEL0, 32'h0, HPP_RESP_OKAY);
		rchk(12'h100, 32'h1, HPP_RESP_OKAY);
		rchk(12'h200, 32'h0, HPP_RESP_ERR);
		wr(HPP_OFS_SMO0, 32'h46);
		rchk(HPP_OFS_SMO0, 32'h3B, HPP_RESP_OKAY);
		wr(HPP_OFS_SMO0, 32'h0);
	endtask : t_regs
	// four axes asked of generator one, lowest three taken; axis 1 both ways
	task automatic t_travel();
		wr(HPP_OFS_SEL0, 32'h1D);
		wr(12'h100, 32'd100);
		wr(HPP_OFS_ENABLE, 32'h1);
		repeat (700) @(posedge clk);
		base = acc;
		u_pg.send(0, 7, 1'b0);
		repeat (250) @(posedge clk);
		chk("travel up", dlt(0), 32'd700);
		chk("axis2 idle", dlt(1), 32'd0);
		chk("axis5 excess", dlt(4), 32'd0);
		base = acc;
		u_pg.send(0, 3, 1'b1);
		repeat (250) @(posedge clk);
		chk("travel down", dlt(0), -32'sd300);
	endtask : t_travel
	// four axes selected, a shared axis, a bad magnification, and slot one pulses
	task automatic t_multi();
		wr(HPP_OFS_SEL1, 32'hF0);
		wr(HPP_OFS_SEL2, 32'h201);
		wr(12'h110, 32'd3);
		wr(12'h124, 32'd0);
		wr(HPP_OFS_ENABLE, 32'h7);
		repeat (700) @(posedge clk);
		rchk(HPP_OFS_ERRFLG, 32'h1, HPP_RESP_OKAY);
		rchk(HPP_OFS_ERR2, 32'h200, HPP_RESP_OKAY);
		rchk(HPP_OFS_STATUS, 32'h27D, HPP_RESP_OKAY);
		base = acc;
		u_pg.send(1, 4, 1'b0);
		u_pg.send(2, 5, 1'b0);
		u_pg.send(3, 6, 1'b0);
		repeat (250) @(posedge clk);
		chk("axis5", dlt(4), 32'd12);
		chk("axis7", dlt(6), 32'd4);
		chk("axis8", dlt(7), 32'd0);
		chk("axis10", dlt(9), 32'd5);
		chk("axis1", dlt(0), 32'd0);
		wr(HPP_OFS_ERRFLG, 32'h1);
		rchk(HPP_OFS_ERRFLG, 32'h0, HPP_RESP_OKAY);
	endtask : t_multi
	task automatic t_off();
		wr(HPP_OFS_ENABLE, 32'h0);
		repeat (1000) @(posedge clk);
		rchk(HPP_OFS_STATUS, 32'h0, HPP_RESP_OKAY);
		base = acc;
		u_pg.send(0, 5, 1'b0);
		repeat (250) @(posedge clk);
		chk("disabled", dlt(0), 32'd0);
	endtask : t_off
	// axis 12 lies outside the reduced variant
	task automatic t_variant();
		wr(HPP_OFS_VARIANT, 32'h1);
		wr(HPP_OFS_SEL0, 32'h800);
		wr(HPP_OFS_ENABLE, 32'h1);
		repeat (700) @(posedge clk);
		rchk(HPP_OFS_STATUS, 32'h0, HPP_RESP_OKAY);
	endtask : t_variant
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		srst = 1'b1; slot = 2'b11; cyc = 0; n_fail = 0; samples_checked = 0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'h0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_travel();
		t_multi();
		t_off();
		t_variant();
		give_verdict();
	end
endmodule : handwheel_pulse_positioning_tb
